// File: inc/ocr_pkg.sv
// Shared constants and types for the overcurrent cut-off and retry block
package ocr_pkg;
    // Reference source selection
    localparam int REF_SEL_W = 5;
    localparam int REF_LEVELS = 24;
    localparam logic [4:0] REF_SEL_VDD3 = 5'h18;
    localparam logic [4:0] REF_SEL_VDD4 = 5'h19;
    localparam logic [4:0] REF_SEL_PIN = 5'h1A;
    localparam int REF_MIN_MV = 50;
    localparam int REF_MAX_MV = 1200;
    localparam int REF_STEP_MV = (REF_MAX_MV - REF_MIN_MV) / (REF_LEVELS - 1);
    localparam int MV_W = 12;
    // Clock and recovery time
    localparam int CLK_MHZ = 25;
    localparam int RECOVERY_US = 100;
    localparam int RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
    localparam int DLY_W = 24;
    // Reset values
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_CMP = 1'b0;

    typedef enum logic [1:0] {
        OCR_OFF,
        OCR_ON,
        OCR_RECOVER
    } ocr_state_t;

    // Measurement inputs: sense voltage and the supply and pin levels in mV
    typedef struct packed {
        logic [11:0] sense_mv;
        logic [11:0] vdd_mv;
        logic [11:0] pin_mv;
    } ocr_sense_t;
endpackage : ocr_pkg

// File: hdl/ocr_recovery_delay.sv
// Restartable recovery delay: output low while counting, high once expired
module ocr_recovery_delay #(
    parameter int DLY_W = ocr_pkg::DLY_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Control
    input wire logic restart_i,
    input wire logic [DLY_W-1:0] length_i,
    // Status
    output logic done_o
);
    logic [DLY_W-1:0] cnt_q, cnt_d;
    logic done_q, done_d;

    always_comb begin
        cnt_d = cnt_q;
        done_d = done_q;
        if (restart_i) begin // see (R9)
            cnt_d = length_i;
            done_d = 1'b0;
        end else if (cnt_q > 1) begin
            cnt_d = cnt_q - 1'b1;
        end else begin
            cnt_d = '0;
            done_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            done_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;
endmodule : ocr_recovery_delay

// File: hdl/ocr_cutoff.sv
// Overcurrent cut-off with timed retry driving the load switch enable

// How it works
// (R1) Switch enable comes only from this internal logic, no external path.
// (R2) Comparator works only while the power-up flag is high.
// (R3) Before power-up: comparator, gate and enable all low.
// (R4) After power-up, current below limit drives enable high.
// (R5) Current above limit drops comparator then enable, opening the switch.
// (R6) Reference: 24 levels 50-1200 mV, supply/3, supply/4 or pin.
// (R7) After cut-off, enable stays low for the recovery delay, then returns.
// (R8) Never latches off; persistent fault cycles at the delay interval.
// (R9) Enable is comparator AND delay output; comparator fall restarts delay.
module ocr_cutoff #(
    parameter int RECOVERY_CYC = ocr_pkg::RECOVERY_CYC,
    parameter int DLY_W = ocr_pkg::DLY_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Power-up flag and reference selection (pins)
    input wire logic power_up_flag_i,
    input wire logic [ocr_pkg::REF_SEL_W-1:0] ref_sel_i,
    // Analog levels, digitised
    input wire ocr_pkg::ocr_sense_t sense_i,
    // Switch control and status
    output logic switch_enable_o,
    output logic current_comparator_o,
    output logic [1:0] state_o
);
    // Reference level in mV for a selection code
    function automatic logic [11:0] ref_mv(
        input logic [4:0] sel,
        input ocr_pkg::ocr_sense_t s
    );
        logic [11:0] r;
        r = 12'h000;
        if (sel < 5'(ocr_pkg::REF_LEVELS)) begin
            r = 12'(ocr_pkg::REF_MIN_MV + sel * ocr_pkg::REF_STEP_MV);
        end else if (sel == ocr_pkg::REF_SEL_VDD3) begin
            r = 12'(s.vdd_mv / 3);
        end else if (sel == ocr_pkg::REF_SEL_VDD4) begin
            r = 12'(s.vdd_mv / 4);
        end else if (sel == ocr_pkg::REF_SEL_PIN) begin
            r = s.pin_mv;
        end
        return r;
    endfunction : ref_mv

    // High while sense is at or below the selected reference
    function automatic logic within_limit(
        input logic [4:0] sel,
        input ocr_pkg::ocr_sense_t s
    );
        return s.sense_mv <= ref_mv(sel, s);
    endfunction : within_limit

    // Two-input gate feeding the switch enable
    function automatic logic two_input_gate(
        input logic cmp,
        input logic dly
    );
        return cmp & dly;
    endfunction : two_input_gate

    // Input synchronisers, two flops per pin
    logic pwr_s1_q, pwr_s1_d;
    logic pwr_s2_q, pwr_s2_d;
    logic [ocr_pkg::REF_SEL_W-1:0] sel_s1_q, sel_s1_d;
    logic [ocr_pkg::REF_SEL_W-1:0] sel_s2_q, sel_s2_d;
    ocr_pkg::ocr_sense_t sns_s1_q, sns_s1_d;
    ocr_pkg::ocr_sense_t sns_s2_q, sns_s2_d;

    always_comb begin
        pwr_s1_d = power_up_flag_i;
        pwr_s2_d = pwr_s1_q;
        sel_s1_d = ref_sel_i;
        sel_s2_d = sel_s1_q;
        sns_s1_d = sense_i;
        sns_s2_d = sns_s1_q;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pwr_s1_q <= 1'b0;
            pwr_s2_q <= 1'b0;
            sel_s1_q <= 5'h00;
            sel_s2_q <= 5'h00;
            sns_s1_q <= '0;
            sns_s2_q <= '0;
        end else begin
            pwr_s1_q <= pwr_s1_d;
            pwr_s2_q <= pwr_s2_d;
            sel_s1_q <= sel_s1_d;
            sel_s2_q <= sel_s2_d;
            sns_s1_q <= sns_s1_d;
            sns_s2_q <= sns_s2_d;
        end
    end

    // Settle filter: a word caught mid-change would give a false trip,
    // so a word is taken only once two samples agree
    logic [ocr_pkg::REF_SEL_W-1:0] sel_s3_q, sel_s3_d;
    ocr_pkg::ocr_sense_t sns_s3_q, sns_s3_d;
    logic [ocr_pkg::REF_SEL_W-1:0] sel_q, sel_d;
    ocr_pkg::ocr_sense_t sns_q, sns_d;
    logic settled;

    always_comb begin
        sel_s3_d = sel_s2_q;
        sns_s3_d = sns_s2_q;
        settled = (sel_s2_q == sel_s3_q) && (sns_s2_q == sns_s3_q);
        sel_d = sel_q;
        sns_d = sns_q;
        if (settled) begin
            sel_d = sel_s3_q;
            sns_d = sns_s3_q;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sel_s3_q <= 5'h00;
            sns_s3_q <= '0;
            sel_q <= 5'h00;
            sns_q <= '0;
        end else begin
            sel_s3_q <= sel_s3_d;
            sns_s3_q <= sns_s3_d;
            sel_q <= sel_d;
            sns_q <= sns_d;
        end
    end

    // Comparator, held low until the power-up flag is seen
    logic cmp_q, cmp_d;
    logic restart;
    logic dly_done;

    always_comb begin
        cmp_d = ocr_pkg::RST_CMP;
        if (pwr_s2_q) begin // see (R2) see (R3)
            cmp_d = within_limit(sel_q, sns_q); // see (R5) see (R6)
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmp_q <= ocr_pkg::RST_CMP; // see (R3)
        end else begin
            cmp_q <= cmp_d;
        end
    end

    // Each fall of the comparator restarts the recovery delay
    assign restart = cmp_q & ~cmp_d; // see (R9)

    ocr_recovery_delay #(
        .DLY_W(DLY_W)
    ) u_recovery_delay (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .restart_i(restart),
        .length_i(DLY_W'(RECOVERY_CYC)),
        .done_o(dly_done)
    );

    // Switch enable from the internal gate only
    logic en_q, en_d;

    always_comb begin
        en_d = two_input_gate(cmp_q, dly_done); // see (R1) see (R4) see (R9)
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            en_q <= ocr_pkg::RST_ENABLE; // see (R3)
        end else begin
            en_q <= en_d;
        end
    end

    // Status state
    ocr_pkg::ocr_state_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ocr_pkg::OCR_OFF: begin
                if (en_d) begin
                    st_d = ocr_pkg::OCR_ON;
                end
            end
            ocr_pkg::OCR_ON: begin
                if (!en_d) begin
                    st_d = dly_done ? ocr_pkg::OCR_OFF : ocr_pkg::OCR_RECOVER;
                end
            end
            ocr_pkg::OCR_RECOVER: begin
                // Retry after delay, never latched off
                if (dly_done) begin // see (R7) see (R8)
                    st_d = en_d ? ocr_pkg::OCR_ON : ocr_pkg::OCR_OFF;
                end
            end
            default: begin
                st_d = ocr_pkg::OCR_OFF;
            end
        endcase
        if (!cmp_q && !dly_done) begin
            st_d = ocr_pkg::OCR_RECOVER;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_q <= ocr_pkg::OCR_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    assign switch_enable_o = en_q;
    assign current_comparator_o = cmp_q;
    assign state_o = st_q;
endmodule : ocr_cutoff

// File: verification/ocr_load_model.sv
// Sense resistor and protected load behind the switch
module ocr_load_model (
    // Switch side
    input wire logic switch_enable_i,
    input wire logic [15:0] load_ma_i,
    // Levels seen by the block
    output ocr_pkg::ocr_sense_t sense_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Open switch carries no current; 0.2 ohm gives mA / 5
    // Supply at 3000 mV, reference pin at 600 mV
    assign sense_o = {
        switch_enable_i ? 12'(load_ma_i / 16'h0005) : 12'h000,
        12'hBB8,
        12'h258
    };
endmodule : ocr_load_model

// File: verification/ocr_cutoff_assertions.sv
// Port checker for the cut-off block
module ocr_cutoff_assertions #(
    parameter int RECOVERY_CYC = 20
) (
    // Clock, reset, power flag
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic power_up_flag_i,
    // Outputs
    input wire logic switch_enable_o,
    input wire logic current_comparator_o,
    input wire logic [1:0] state_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    logic [15:0] hi_q;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !current_comparator_o) hi_q <= 16'h0000;
        else if (hi_q != 16'hFFFF) hi_q <= hi_q + 16'h0001;
    end
    en_cmp_a: assert property (
        switch_enable_o |-> $past(current_comparator_o))
        else $error("enable high without comparator");
    cut_off_a: assert property (
        $fell(current_comparator_o) |=> !switch_enable_o [*8])
        else $error("enable back too soon after cut-off");
    pwr_cmp_a: assert property (
        !power_up_flag_i [*4] |=> !current_comparator_o)
        else $error("comparator high without power-up");
    pwr_en_a: assert property (
        !power_up_flag_i [*4] |=> !switch_enable_o)
        else $error("enable high without power-up");
    fault_retry_a: assert property (
        $fell(switch_enable_o) |-> ##[1:60] switch_enable_o)
        else $error("no retry after cut-off");
    steady_on_a: assert property (
        hi_q > 16'(RECOVERY_CYC + 4) |-> switch_enable_o)
        else $error("enable low with current in limit");
    on_state_a: assert property (
        switch_enable_o [*2] |-> state_o == 2'h1)
        else $error("state not on while enabled");
    off_state_a: assert property (
        !switch_enable_o [*2] |-> state_o != 2'h1)
        else $error("state on while disabled");
    cover property ($fell(switch_enable_o));
    cover property ($rose(switch_enable_o));
    cover property (hi_q > 16'(RECOVERY_CYC + 4));
endmodule : ocr_cutoff_assertions
bind ocr_cutoff ocr_cutoff_assertions #(.RECOVERY_CYC(RECOVERY_CYC)) u_chk (
    .ref_clk_i, .rst_i, .power_up_flag_i, .switch_enable_o,
    .current_comparator_o, .state_o);

// File: verification/ocr_cutoff_bench.sv
// Bench for the overcurrent cut-off and retry block
module ocr_cutoff_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pwr = 1'b0;
    logic [4:0] sel = 5'h00;
    logic [15:0] ma = 16'h0000;
    logic en;
    logic cmp;
    logic [1:0] st;
    ocr_pkg::ocr_sense_t sense;
    int miscompares = 0;
    int tests_run = 0;
    always #20 clk = ~clk;
    ocr_load_model u_ocr_load_model (.switch_enable_i(en),
        .load_ma_i(ma), .sense_o(sense));
    ocr_cutoff #(.RECOVERY_CYC(20)) u_ocr_cutoff (.ref_clk_i(clk),
        .rst_i(rst), .power_up_flag_i(pwr), .ref_sel_i(sel),
        .sense_i(sense), .switch_enable_o(en),
        .current_comparator_o(cmp), .state_o(st));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chk(input string what, input logic e, input logic s);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %b seen %b", what, e, s);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic t_power;
        cyc(10);
        chk("comparator", 1'b0, cmp);
        chk("enable", 1'b0, en);
        chk("state off", 1'b1, st == ocr_pkg::OCR_OFF);
        pwr = 1'b1;
        cyc(8);
        chk("enable", 1'b1, en);
        chk("state on", 1'b1, st == ocr_pkg::OCR_ON);
        $display("t_power done");
    endtask : t_power
    task automatic t_ref;
        int mv[6] = '{50, 1200, 1000, 750, 600, 0};
        logic [4:0] code[6] = '{5'h00, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1F};
        for (int i = 0; i < 6; i++) begin
            sel = code[i];
            ma = 16'(5 * mv[i]);
            cyc(40);
            chk("cmp at limit", 1'b1, cmp);
            chk("en at limit", 1'b1, en);
            ma = 16'(5 * mv[i] + 5);
            cyc(8);
            chk("en over", 1'b0, en);
            chk("state recover", 1'b1, st == ocr_pkg::OCR_RECOVER);
            ma = 16'h0000;
        end
        $display("t_ref done");
    endtask : t_ref
    task automatic t_retry;
        int rises = 0;
        int lo = 0;
        int min_lo = 999;
        sel = 5'h00;
        cyc(40);
        ma = 16'h07D0;
        repeat (200) begin
            cyc(1);
            if (!en) lo++;
            else begin
                if (lo > 0) rises++;
                if (lo > 0 && lo < min_lo) min_lo = lo;
                lo = 0;
            end
        end
        chk("retries", 1'b1, rises >= 3);
        chk("off span", 1'b1, min_lo >= 20);
        $display("t_retry done");
    endtask : t_retry
    initial begin
        cyc(5000);
        miscompares++;
        $display("ERROR watchdog expected done seen hang");
        conclude();
    end
    initial begin
        cyc(8);
        rst = 1'b0;
        t_power();
        t_ref();
        t_retry();
        conclude();
    end
endmodule : ocr_cutoff_bench
